// File: hdl/dual_uart_pkg.sv
// Functional notes
// - one reference clock times all logic and baud.
// - active-low aresetn input brings device up.
// - DTR1/RTS1 levels at reset pick mode.
// - mode 0: two ports, port 0 full modem.
// - mode 0: both ports flow control, RS485 indicator.
// - modes 1-3: only port 1 active.
// - transmit line idles high.
// - start, 8 data, optional parity, 1/2 stops.
// - baud from 1200 up to 9M.
// - separate transmit and receive buffers per port.
// - automatic flow control off after reset.
// - with flow on, start only while CTS low.
// - RTS low with room, high near full; code lowers RTS again only once the buffer is empty.
// - receive within 2%, transmit within 1%.
// - eight general purpose input/output lines.
// - DTR0 pulled low: DTR pins show sending.
// - DTR, RTS, CTS are active low.
package dual_uart_pkg;

  localparam longint CLK_HZ   = 64'd10_000_000;
  localparam longint DEF_BAUD = 64'd115200;
  localparam int     ACC_W    = 24;
  localparam logic [ACC_W-1:0] DEF_INC  =
    ACC_W'((DEF_BAUD << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_HALF = 24'h800000;

  localparam int BUF_AW = 4;
  localparam logic [BUF_AW:0] NEAR_FULL = 5'h0C;
  localparam logic [BUF_AW:0] BUF_FULL  = 5'h10;
  localparam logic [1:0]      STRAP_WAIT = 2'h3;
  localparam logic [1:0]      MODE_DUAL  = 2'h0;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CFG  = 8'h00;
  localparam logic [7:0] OFF_BAUD = 8'h04;
  localparam logic [7:0] OFF_TXD  = 8'h08;
  localparam logic [7:0] OFF_RXD  = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h40;
  localparam logic [7:0] OFF_GPO  = 8'h44;
  localparam logic [7:0] OFF_GOE  = 8'h48;
  localparam logic [7:0] OFF_GPI  = 8'h4C;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  localparam int SY_RTS1 = 0;
  localparam int SY_DTR1 = 1;
  localparam int SY_DTR0 = 2;
  localparam int SY_RI0  = 3;
  localparam int SY_DCD0 = 4;
  localparam int SY_DSR0 = 5;
  localparam int SY_CTS0 = 6;
  localparam int SY_RXD0 = 8;
  localparam int SY_GPI  = 10;
  localparam int SYNC_W  = 18;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } bit_st_t;

  typedef struct packed {
    logic rts;
    logic dtr;
    logic flow;
    logic two_stop;
    logic par_odd;
    logic par_en;
  } cfg_t;

  typedef struct packed {
    logic ri;
    logic dcd;
    logic dsr;
    logic cts;
    logic perr;
    logic ferr;
    logic ovr;
    logic rx_empty;
    logic tx_full;
    logic tx_busy;
  } stat_t;

  typedef struct packed {
    cfg_t              cfg;
    logic [ACC_W-1:0]  inc;
    bit_st_t           tx_st;
    logic [ACC_W-1:0]  tx_acc;
    logic [7:0]        tx_sh;
    logic [2:0]        tx_cnt;
    logic              tx_par;
    logic              txd;
    bit_st_t           rx_st;
    logic [ACC_W-1:0]  rx_acc;
    logic [7:0]        rx_sh;
    logic [2:0]        rx_cnt;
    logic              rx_prev;
    logic              ovr;
    logic              ferr;
    logic              perr;
    logic              rts_n;
    logic [BUF_AW:0]   twp;
    logic [BUF_AW:0]   trp;
    logic [BUF_AW:0]   rwp;
    logic [BUF_AW:0]   rrp;
  } port_t;

endpackage

// File: hdl/uart_buf_ram.sv
`timescale 1ns/1ps
`default_nettype none
module uart_buf_ram #(
  parameter int DW = 8,
  parameter int AW = 4
) (
  input  wire logic          aclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // bypass so a word pushed into an empty buffer is seen at once
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // uart_buf_ram
`default_nettype wire

// File: hdl/dual_uart.sv
`timescale 1ns/1ps
`default_nettype none
module dual_uart (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        rxd0,
  input  wire logic        rxd1,
  output var  logic        txd0,
  output var  logic        txd1,
  input  wire logic        cts0_n,
  input  wire logic        cts1_n,
  input  wire logic        dsr0_n,
  input  wire logic        dcd0_n,
  input  wire logic        ri0_n,
  output var  logic        rts0_n,
  input  wire logic        rts1_n_i,
  output var  logic        rts1_n_o,
  output var  logic        rts1_n_oe,
  input  wire logic        dtr0_n_i,
  output var  logic        dtr0_n_o,
  output var  logic        dtr0_n_oe,
  input  wire logic        dtr1_n_i,
  output var  logic        dtr1_n_o,
  output var  logic        dtr1_n_oe,
  input  wire logic [7:0]  gpio_i,
  output var  logic [7:0]  gpio_o,
  output var  logic [7:0]  gpio_oe
);

  typedef struct packed {
    dual_uart_pkg::port_t [1:0]           p;
    logic [dual_uart_pkg::SYNC_W-1:0]     s1;
    logic [dual_uart_pkg::SYNC_W-1:0]     s2;
    logic [1:0]                           mode;
    logic                                 tx_active_indicator_sel;
    logic [1:0]                           strap_cnt;
    logic                                 strap_done;
    logic [1:0]                           dtr_n;
    logic [7:0]                           gpo;
    logic [7:0]                           goe;
    logic                                 awready;
    logic                                 wready;
    logic                                 aw_have;
    logic                                 w_have;
    logic [7:0]                           awaddr;
    logic [31:0]                          wdata;
    logic [3:0]                           wstrb;
    logic                                 bvalid;
    logic [1:0]                           bresp;
    logic                                 arready;
    logic                                 rd_pend;
    logic [7:0]                           araddr;
    logic                                 rvalid;
    logic [1:0]                           rresp;
    logic [31:0]                          rdata;
  } state_t;

  localparam int AW = dual_uart_pkg::BUF_AW;

  function automatic logic [AW:0] fill(logic [AW:0] wp, logic [AW:0] rp);
    return wp - rp;
  endfunction

  function automatic logic [7:0] port_off(logic [7:0] a);
    return {3'h0, a[4:0]};
  endfunction

  function automatic state_t rst_val();
    state_t s;
    s = '0;
    s.s1 = '1;
    s.s2 = '1;
    s.dtr_n = '1;
    for (int i = 0; i < 2; i++) begin
      s.p[i].txd = 1'b1;
      s.p[i].rts_n = 1'b1;
      s.p[i].rx_prev = 1'b1;
      s.p[i].inc = dual_uart_pkg::DEF_INC;
    end
    return s;
  endfunction

  localparam state_t RST = rst_val();

  state_t r;
  state_t n;
  logic [dual_uart_pkg::SYNC_W-1:0] pins;
  logic [1:0]       tx_we;
  logic [1:0]       rx_we;
  logic [1:0][7:0]  rx_wd;
  logic [1:0][7:0]  tx_rd;
  logic [1:0][7:0]  rx_rd;

  assign pins = {gpio_i, rxd1, rxd0, cts1_n, cts0_n, dsr0_n, dcd0_n,
                 ri0_n, dtr0_n_i, dtr1_n_i, rts1_n_i};

  ////////////////////////////////////////////////////////////////////////
  // buffers: one transmit and one receive memory per port
  for (genvar g = 0; g < 2; g++) begin : g_buf
    uart_buf_ram #(.DW(8), .AW(AW)) u_tx (
      .aclk  (aclk),
      .we    (tx_we[g]),
      .waddr (r.p[g].twp[AW-1:0]),
      .wdata (r.wdata[7:0]),
      .raddr (r.p[g].trp[AW-1:0]),
      .rdata (tx_rd[g])
    );
    uart_buf_ram #(.DW(8), .AW(AW)) u_rx (
      .aclk  (aclk),
      .we    (rx_we[g]),
      .waddr (r.p[g].rwp[AW-1:0]),
      .wdata (rx_wd[g]),
      .raddr (r.p[g].rrp[AW-1:0]),
      .rdata (rx_rd[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        pi;
    logic        ok;
    logic        act;
    logic        rxd;
    logic        cts_n;
    logic [7:0]  off;
    logic [24:0] ts;
    logic [24:0] rs;
    logic [AW:0] rf;
    dual_uart_pkg::stat_t sv;
    pi = 1'b0;
    ok = 1'b1;
    act = 1'b0;
    rxd = 1'b1;
    cts_n = 1'b1;
    off = 8'h00;
    ts = '0;
    rs = '0;
    rf = '0;
    sv = '0;
    n = r;
    tx_we = '0;
    rx_we = '0;
    rx_wd = '0;
    n.s1 = pins;
    n.s2 = r.s1;

    // strap pins float during and just after reset, then become outputs
    if (!r.strap_done) begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == dual_uart_pkg::STRAP_WAIT) begin
        n.strap_done = 1'b1;
        n.mode = {~r.s2[dual_uart_pkg::SY_DTR1],
                  ~r.s2[dual_uart_pkg::SY_RTS1]};
        n.tx_active_indicator_sel = ~r.s2[dual_uart_pkg::SY_DTR0];
      end
    end

    // write channel
    if (awvalid && r.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && r.wready) begin
      n.w_have = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (r.aw_have && r.w_have && !r.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      if (r.awaddr >= dual_uart_pkg::OFF_MODE) begin
        unique case (r.awaddr)
          dual_uart_pkg::OFF_GPO: if (r.wstrb[0]) n.gpo = r.wdata[7:0];
          dual_uart_pkg::OFF_GOE: if (r.wstrb[0]) n.goe = r.wdata[7:0];
          dual_uart_pkg::OFF_MODE, dual_uart_pkg::OFF_GPI: ok = 1'b1;
          default: ok = 1'b0;
        endcase
      end else begin
        pi = r.awaddr[5];
        off = port_off(r.awaddr);
        unique case (off)
          dual_uart_pkg::OFF_CFG: begin
            if (r.wstrb[0]) n.p[pi].cfg = r.wdata[5:0];
          end
          dual_uart_pkg::OFF_BAUD: begin
            for (int b = 0; b < 3; b++) begin
              if (r.wstrb[b]) n.p[pi].inc[8*b +: 8] = r.wdata[8*b +: 8];
            end
          end
          dual_uart_pkg::OFF_TXD: begin
            // a full buffer refuses the byte rather than overwrite one
            if (fill(r.p[pi].twp, r.p[pi].trp) == dual_uart_pkg::BUF_FULL)
            begin
              ok = 1'b0;
            end else if (r.wstrb[0]) begin
              tx_we[pi] = 1'b1;
              n.p[pi].twp = r.p[pi].twp + 1'b1;
            end
          end
          dual_uart_pkg::OFF_RXD: ok = 1'b1;
          dual_uart_pkg::OFF_STAT: begin
            sv = r.wdata[9:0];
            if (r.wstrb[0] && sv.ovr) n.p[pi].ovr = 1'b0;
            if (r.wstrb[0] && sv.ferr) n.p[pi].ferr = 1'b0;
            if (r.wstrb[0] && sv.perr) n.p[pi].perr = 1'b0;
          end
          default: ok = 1'b0;
        endcase
      end
      n.bresp = ok ? dual_uart_pkg::RESP_OK : dual_uart_pkg::RESP_ERR;
    end
    if (r.bvalid && bready) n.bvalid = 1'b0;
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    // read channel: one cycle to let buffer data settle
    if (arvalid && r.arready) begin
      n.rd_pend = 1'b1;
      n.araddr = araddr;
    end
    if (r.rd_pend) begin
      n.rd_pend = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = dual_uart_pkg::RESP_OK;
      n.rdata = '0;
      pi = r.araddr[5];
      off = port_off(r.araddr);
      sv = '0;
      sv.tx_busy = r.p[pi].tx_st != dual_uart_pkg::ST_IDLE;
      sv.tx_full = fill(r.p[pi].twp, r.p[pi].trp) ==
                   dual_uart_pkg::BUF_FULL;
      sv.rx_empty = fill(r.p[pi].rwp, r.p[pi].rrp) == '0;
      sv.ovr = r.p[pi].ovr;
      sv.ferr = r.p[pi].ferr;
      sv.perr = r.p[pi].perr;
      sv.cts = ~r.s2[dual_uart_pkg::SY_CTS0 + int'(pi)];
      if (!pi) begin
        sv.dsr = ~r.s2[dual_uart_pkg::SY_DSR0];
        sv.dcd = ~r.s2[dual_uart_pkg::SY_DCD0];
        sv.ri = ~r.s2[dual_uart_pkg::SY_RI0];
      end
      if (r.araddr >= dual_uart_pkg::OFF_MODE) begin
        unique case (r.araddr)
          dual_uart_pkg::OFF_MODE: n.rdata = {29'h0, r.tx_active_indicator_sel, r.mode};
          dual_uart_pkg::OFF_GPO: n.rdata = {24'h0, r.gpo};
          dual_uart_pkg::OFF_GOE: n.rdata = {24'h0, r.goe};
          dual_uart_pkg::OFF_GPI:
            n.rdata = {24'h0, r.s2[dual_uart_pkg::SY_GPI +: 8]};
          default: n.rresp = dual_uart_pkg::RESP_ERR;
        endcase
      end else begin
        unique case (off)
          dual_uart_pkg::OFF_CFG: n.rdata = {26'h0, r.p[pi].cfg};
          dual_uart_pkg::OFF_BAUD: n.rdata = {8'h00, r.p[pi].inc};
          dual_uart_pkg::OFF_TXD: n.rdata = '0;
          dual_uart_pkg::OFF_RXD: begin
            if (!sv.rx_empty) begin
              n.rdata = {23'h0, 1'b1, rx_rd[pi]};
              n.p[pi].rrp = r.p[pi].rrp + 1'b1;
            end
          end
          dual_uart_pkg::OFF_STAT: n.rdata = {22'h0, sv};
          default: n.rresp = dual_uart_pkg::RESP_ERR;
        endcase
      end
    end
    if (r.rvalid && rready) n.rvalid = 1'b0;
    n.arready = !n.rd_pend && !n.rvalid;

    // serial ports
    for (int i = 0; i < 2; i++) begin
      act = r.strap_done &&
            (i == 1 || r.mode == dual_uart_pkg::MODE_DUAL);
      rxd = r.s2[dual_uart_pkg::SY_RXD0 + i];
      cts_n = r.s2[dual_uart_pkg::SY_CTS0 + i];
      // phase accumulator: exact to one part in 2^24 of the clock
      ts = {1'b0, r.p[i].tx_acc} + {1'b0, r.p[i].inc};
      rs = {1'b0, r.p[i].rx_acc} + {1'b0, r.p[i].inc};
      n.p[i].tx_acc = ts[23:0];
      n.p[i].rx_acc = rs[23:0];

      unique case (r.p[i].tx_st)
        dual_uart_pkg::ST_IDLE: begin
          n.p[i].txd = 1'b1;
          if (act && fill(r.p[i].twp, r.p[i].trp) != '0 &&
              (!r.p[i].cfg.flow || !cts_n)) begin
            n.p[i].tx_st = dual_uart_pkg::ST_START;
            n.p[i].tx_acc = '0;
            n.p[i].trp = r.p[i].trp + 1'b1;
            n.p[i].tx_sh = tx_rd[i];
            n.p[i].tx_par = (^tx_rd[i]) ^ r.p[i].cfg.par_odd;
            n.p[i].txd = 1'b0;
          end
        end
        dual_uart_pkg::ST_START: begin
          if (ts[24]) begin
            n.p[i].tx_st = dual_uart_pkg::ST_DATA;
            n.p[i].txd = r.p[i].tx_sh[0];
            n.p[i].tx_sh = {1'b0, r.p[i].tx_sh[7:1]};
            n.p[i].tx_cnt = '0;
          end
        end
        dual_uart_pkg::ST_DATA: begin
          if (ts[24] && r.p[i].tx_cnt == 3'h7) begin
            n.p[i].tx_cnt = '0;
            if (r.p[i].cfg.par_en) begin
              n.p[i].tx_st = dual_uart_pkg::ST_PAR;
              n.p[i].txd = r.p[i].tx_par;
            end else begin
              n.p[i].tx_st = dual_uart_pkg::ST_STOP;
              n.p[i].txd = 1'b1;
            end
          end else if (ts[24]) begin
            n.p[i].txd = r.p[i].tx_sh[0];
            n.p[i].tx_sh = {1'b0, r.p[i].tx_sh[7:1]};
            n.p[i].tx_cnt = r.p[i].tx_cnt + 3'h1;
          end
        end
        dual_uart_pkg::ST_PAR: begin
          if (ts[24]) begin
            n.p[i].tx_st = dual_uart_pkg::ST_STOP;
            n.p[i].txd = 1'b1;
          end
        end
        dual_uart_pkg::ST_STOP: begin
          if (ts[24] && r.p[i].cfg.two_stop && r.p[i].tx_cnt == '0) begin
            n.p[i].tx_cnt = 3'h1;
          end else if (ts[24]) begin
            n.p[i].tx_st = dual_uart_pkg::ST_IDLE;
          end
        end
        default: n.p[i].tx_st = dual_uart_pkg::ST_IDLE;
      endcase

      n.p[i].rx_prev = rxd;
      unique case (r.p[i].rx_st)
        dual_uart_pkg::ST_IDLE: begin
          if (act && r.p[i].rx_prev && !rxd) begin
            // half a bit from the edge lands each sample mid-bit
            n.p[i].rx_st = dual_uart_pkg::ST_START;
            n.p[i].rx_acc = dual_uart_pkg::ACC_HALF;
          end
        end
        dual_uart_pkg::ST_START: begin
          if (rs[24]) begin
            n.p[i].rx_st = rxd ? dual_uart_pkg::ST_IDLE
                               : dual_uart_pkg::ST_DATA;
            n.p[i].rx_cnt = '0;
          end
        end
        dual_uart_pkg::ST_DATA: begin
          if (rs[24]) begin
            n.p[i].rx_sh = {rxd, r.p[i].rx_sh[7:1]};
            n.p[i].rx_cnt = r.p[i].rx_cnt + 3'h1;
            if (r.p[i].rx_cnt == 3'h7) begin
              n.p[i].rx_st = r.p[i].cfg.par_en ? dual_uart_pkg::ST_PAR
                                               : dual_uart_pkg::ST_STOP;
            end
          end
        end
        dual_uart_pkg::ST_PAR: begin
          if (rs[24]) begin
            n.p[i].rx_st = dual_uart_pkg::ST_STOP;
            if (rxd != ((^r.p[i].rx_sh) ^ r.p[i].cfg.par_odd)) begin
              n.p[i].perr = 1'b1;
            end
          end
        end
        dual_uart_pkg::ST_STOP: begin
          if (rs[24]) begin
            n.p[i].rx_st = dual_uart_pkg::ST_IDLE;
            if (!rxd) begin
              n.p[i].ferr = 1'b1;
            end else if (fill(r.p[i].rwp, r.p[i].rrp) ==
                         dual_uart_pkg::BUF_FULL) begin
              n.p[i].ovr = 1'b1;
            end else begin
              rx_we[i] = 1'b1;
              rx_wd[i] = r.p[i].rx_sh;
              n.p[i].rwp = r.p[i].rwp + 1'b1;
            end
          end
        end
        default: n.p[i].rx_st = dual_uart_pkg::ST_IDLE;
      endcase

      // hysteresis: drop request near full, raise again once drained
      rf = fill(r.p[i].rwp, r.p[i].rrp);
      if (!act) begin
        n.p[i].rts_n = 1'b1;
      end else if (!r.p[i].cfg.flow) begin
        n.p[i].rts_n = ~r.p[i].cfg.rts;
      end else if (rf >= dual_uart_pkg::NEAR_FULL) begin
        n.p[i].rts_n = 1'b1;
      end else if (rf == '0) begin
        n.p[i].rts_n = 1'b0;
      end
      if (!act) begin
        n.dtr_n[i] = n.tx_active_indicator_sel ? 1'b0 : 1'b1;
      end else if (n.tx_active_indicator_sel) begin
        n.dtr_n[i] = n.p[i].tx_st != dual_uart_pkg::ST_IDLE;
      end else begin
        n.dtr_n[i] = ~r.p[i].cfg.dtr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign awready   = r.awready;
  assign wready    = r.wready;
  assign bvalid    = r.bvalid;
  assign bresp     = r.bresp;
  assign arready   = r.arready;
  assign rvalid    = r.rvalid;
  assign rresp     = r.rresp;
  assign rdata     = r.rdata;
  assign txd0      = r.p[0].txd;
  assign txd1      = r.p[1].txd;
  assign rts0_n    = r.p[0].rts_n;
  assign rts1_n_o  = r.p[1].rts_n;
  assign rts1_n_oe = r.strap_done;
  assign dtr0_n_o  = r.dtr_n[0];
  assign dtr0_n_oe = r.strap_done;
  assign dtr1_n_o  = r.dtr_n[1];
  assign dtr1_n_oe = r.strap_done;
  assign gpio_o    = r.gpo;
  assign gpio_oe   = r.goe;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence frame_start1;
    r.p[1].tx_st == dual_uart_pkg::ST_IDLE ##1
    r.p[1].tx_st == dual_uart_pkg::ST_START;
  endsequence

  sequence frame_start0;
    r.p[0].tx_st == dual_uart_pkg::ST_IDLE ##1
    r.p[0].tx_st == dual_uart_pkg::ST_START;
  endsequence

  a_idle_line_high: assert property (
    r.p[1].tx_st == dual_uart_pkg::ST_IDLE |-> r.p[1].txd)
    else $error("transmit line low while idle");
  a_start_bit_low: assert property (
    frame_start1 |-> !r.p[1].txd ##1 !r.p[1].txd)
    else $error("start bit not low");
  a_cts_gates_tx: assert property (
    frame_start0 |-> !$past(r.p[0].cfg.flow, 1) ||
                     !$past(r.s2[dual_uart_pkg::SY_CTS0], 1))
    else $error("frame started while clear to send was high");
  a_flow_off_reset: assert property (
    $past(!aresetn) |-> !r.p[0].cfg.flow && !r.p[1].cfg.flow)
    else $error("flow control on after reset");
  a_rts_near_full: assert property (
    r.p[0].cfg.flow && r.strap_done &&
    fill(r.p[0].rwp, r.p[0].rrp) >= dual_uart_pkg::NEAR_FULL
    |=> r.p[0].rts_n)
    else $error("request to send held low near full");
  a_mode_latch: assert property (
    $rose(r.strap_done) |-> r.mode ==
      {~$past(r.s2[dual_uart_pkg::SY_DTR1]),
       ~$past(r.s2[dual_uart_pkg::SY_RTS1])})
    else $error("mode does not match strap levels");
  a_port0_quiet: assert property (
    r.strap_done && r.mode != dual_uart_pkg::MODE_DUAL
    |-> r.p[0].txd && r.p[0].rts_n)
    else $error("port 0 active outside dual mode");
  a_tx_active_indicator_follows: assert property (
    r.strap_done && r.tx_active_indicator_sel |->
    r.dtr_n[1] == (r.p[1].tx_st != dual_uart_pkg::ST_IDLE))
    else $error("sending indicator does not follow transmitter");
  a_stop_checked: assert property (
    $rose(r.p[0].ferr) |-> $past(r.p[0].rx_st) == dual_uart_pkg::ST_STOP)
    else $error("framing error raised outside stop bit");

endmodule // dual_uart
`default_nettype wire

// File: verif/remote_uart.sv
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
  input  wire logic aclk,
  input  wire logic txd,
  input  wire logic rts_n,
  output var  logic rxd,
  output var  logic cts_n
);
  // truncated bit length stays within one clock of the device's own
  localparam int BIT = int'((64'h1 << 24) / dual_uart_pkg::DEF_INC);
  initial begin
    rxd   = 1'h1;
    cts_n = 1'h0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic set_cts(input logic v);
    @(posedge aclk);
    cts_n <= v;
  endtask
  // a low stop level is only there to provoke a framing error
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'h0};
    wait (rts_n === 1'h0);
    @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge aclk);
    end
    rxd <= 1'h1;
  endtask
  // centre sampling from the start edge; returns mid stop bit, so the
  // next wait cannot mistake a trailing low data bit for a start
  task automatic recv(input int n, output logic [8:0] v);
    v = 9'h000;
    wait (txd === 1'h0);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge aclk);
      v[i] = txd;
    end
    repeat (BIT) @(posedge aclk);
  endtask
endmodule // remote_uart
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, gpio_o, gpio_oe;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, txd0, txd1, rxd0;
  logic        cts0_n, rts0_n, rts1_n_o, rts1_n_oe, dtr0_n_o, dtr0_n_oe;
  logic        dtr1_n_o, dtr1_n_oe;
  logic        dsr0_n, dcd0_n, ri0_n, st_rts1, st_dtr0;
  logic [8:0]  v;
  int          mismatches, total_checks, cycles;
  // released strap pins sit at the level the bench pulls them to
  wire rts1_w = rts1_n_oe ? rts1_n_o : st_rts1;
  wire dtr0_w = dtr0_n_oe ? dtr0_n_o : st_dtr0;
  wire dtr1_w = dtr1_n_oe ? dtr1_n_o : 1'h1;
  dual_uart dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd0(rxd0), .rxd1(txd1), .txd0(txd0), .txd1(txd1), .cts0_n(cts0_n),
    .cts1_n(1'h1), .dsr0_n(dsr0_n), .dcd0_n(dcd0_n), .ri0_n(ri0_n),
    .rts0_n(rts0_n), .rts1_n_i(rts1_w), .rts1_n_o(rts1_n_o),
    .rts1_n_oe(rts1_n_oe), .dtr0_n_i(dtr0_w), .dtr0_n_o(dtr0_n_o),
    .dtr0_n_oe(dtr0_n_oe), .dtr1_n_i(dtr1_w), .dtr1_n_o(dtr1_n_o),
    .dtr1_n_oe(dtr1_n_oe), .gpio_i(gpio_o), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe));
  remote_uart u_peer (.aclk(aclk), .txd(txd0), .rts_n(rts0_n), .rxd(rxd0),
    .cts_n(cts0_n));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dv;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // ceiling is about two and a half times the eighteen slow frames plus register traffic
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {dsr0_n, dcd0_n, ri0_n, st_rts1, st_dtr0} = 5'h1F;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
    rd(8'h00); chk(d, 32'h0, "cfg reset");
    rd(8'h04);
    chk(d, {8'h00, dual_uart_pkg::DEF_INC}, "baud reset");
    rd(8'h40); chk(d, 32'h0, "mode");
    rd(8'h18); chk(r, 32'h2, "unmapped resp");
    wr(8'h44, 32'hA5);
    wr(8'h48, 32'hFF);
    chk(gpio_oe, 32'hFF, "gpio enables");
    rd(8'h4C); chk(d, 32'hA5, "gpi loopback");
    chk(txd0, 32'h1, "txd idle");
    wr(8'h00, 32'h08);
    repeat (3) @(posedge aclk);
    chk(rts0_n, 32'h0, "rts with room");
    u_peer.send(8'hC3, 1'h1);
    repeat (30) @(posedge aclk);
    rd(8'h0C); chk(d, 32'h1C3, "rx byte");
    rd(8'h0C); chk(d, 32'h0, "rx empty");
    // twelve bytes reach the near-full mark; draining lowers the request
    for (int k = 0; k < 12; k++) begin
      u_peer.send(8'(k), 1'h1);
    end
    repeat (30) @(posedge aclk);
    chk(rts0_n, 32'h1, "rts near full");
    for (int k = 0; k < 12; k++) begin
      rd(8'h0C);
      chk(d, 32'h100 | k, "rx order");
    end
    repeat (3) @(posedge aclk);
    chk(rts0_n, 32'h0, "rts drained");
    dsr0_n <= 1'h0;
    ri0_n <= 1'h0;
    u_peer.send(8'h55, 1'h0);
    repeat (30) @(posedge aclk);
    rd(8'h10);
    chk(d, 32'h2D4, "stat framing");
    wr(8'h10, 32'h10);
    rd(8'h10);
    chk(d, 32'h2C4, "stat cleared");
    u_peer.set_cts(1'h1);
    wr(8'h08, 32'h11);
    repeat (200) @(posedge aclk);
    chk(txd0, 32'h1, "tx paused");
    u_peer.set_cts(1'h0);
    u_peer.recv(8, v); chk(v, 32'h11, "tx resumed");
    wr(8'h00, 32'h00);
    wr(8'h08, 32'h5A);
    u_peer.recv(8, v); chk(v, 32'h5A, "tx byte");
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, k ? 32'h3 : 32'h1);
      wr(8'h08, 32'h38);
      // three ones: even parity sends 1, odd sends 0
      u_peer.recv(9, v); chk(v, k ? 32'h038 : 32'h138, "parity");
    end
    // second reset with both straps low: mode 1 and sending indicator
    st_rts1 <= 1'h0;
    st_dtr0 <= 1'h0;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
    rd(8'h40);
    chk(d, 32'h5, "mode strap");
    wr(8'h24, 32'h001797CC);
    wr(8'h28, 32'h3C);
    wr(8'h08, 32'h77);
    repeat (5) @(posedge aclk);
    chk(dtr1_n_o, 32'h1, "sending indicator");
    repeat (300) @(posedge aclk);
    chk(dtr1_n_o, 32'h0, "indicator idle");
    chk(txd0, 32'h1, "port 0 quiet");
    rd(8'h2C);
    chk(d, 32'h13C, "port 1 loopback");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
